// >>> core/can_mode_filter_ctrl.sv
`include "can_mode_filter_defines.svh"
`default_nettype none
module can_mode_filter_ctrl #(
   parameter int ADDR_WIDTH = 12,
   parameter int TIMER_WIDTH = 16,
   parameter int BUF_DEPTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic link_idle,
   input wire logic tx_all_idle,
   input wire logic system_idle,
   output logic tx_abort_all,
   output logic module_active,
   output logic [2:0] mode_status,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [2:0] rx_filter,
   input wire logic [31:0] rx_data,
   output logic fifo_valid,
   input wire logic fifo_ready,
   output can_mode_filter_pkg::rx_rec_s fifo_rec
);
   localparam int NUM_FILTERS = 2 * `FLT_PER_WORD;

   // =======================================================================
   // State
   typedef struct packed {
      can_mode_filter_pkg::ctl_state_e state;
      logic abort_all_tx_request;
      logic [2:0] mode_request;
      logic [2:0] mode_status;
      logic rx_timestamp_capture_enable;
      logic module_on;
      logic stop_in_idle;
      logic module_busy_flag;
      logic halted;
      can_mode_filter_pkg::filter_byte_s [NUM_FILTERS-1:0] filter;
      logic [TIMER_WIDTH-1:0] rx_timestamp_timer;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

   localparam state_s RESET_STATE = '{
      state: can_mode_filter_pkg::CTL_OFF,
      abort_all_tx_request: 1'b0,
      mode_request: `MODE_CONFIG,
      mode_status: `MODE_CONFIG,
      rx_timestamp_capture_enable: 1'b0,
      module_on: 1'b0,
      stop_in_idle: 1'b0,
      module_busy_flag: 1'b0,
      halted: 1'b0,
      filter: {NUM_FILTERS{`FLT_RESET}},
      rx_timestamp_timer: TIMER_WIDTH'(`TIMER_RESET),
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000
   };

   state_s r;
   state_s next_r;

   logic access_wait;
   logic commit;
   logic hit_ctl;
   logic hit_f1;
   logic hit_f4;
   logic wr_ctl;
   logic wr_f1;
   logic wr_f4;
   logic abort_set;
   logic req_reserved;
   logic accepting;
   logic buf_in_valid;
   logic buf_in_ready;
   can_mode_filter_pkg::rx_rec_s buf_in_rec;
   can_mode_filter_pkg::filter_byte_s hit_filter;

   // =======================================================================
   // Bus decode
   // The first access cycle is a wait cycle that registers the answer, so
   // pready, prdata and pslverr all come from flip-flops.
   assign access_wait = psel & penable & ~r.pready;
   assign commit = psel & penable & r.pready;
   assign hit_ctl = paddr == `ADDR_MODULE_CONTROL;
   assign hit_f1 = paddr == `ADDR_FILTER_CONTROL_ONE;
   assign hit_f4 = paddr == `ADDR_FILTER_CONTROL_FOUR;
   assign wr_ctl = commit & pwrite & hit_ctl;
   assign wr_f1 = commit & pwrite & hit_f1;
   assign wr_f4 = commit & pwrite & hit_f4;
   assign abort_set = wr_ctl & pwdata[`CTL_ABORT_BIT];
   assign req_reserved = (r.mode_request == `MODE_RESERVED_A) |
      (r.mode_request == `MODE_RESERVED_B);

   // =======================================================================
   // Receive path
   assign hit_filter = r.filter[rx_filter];
   assign accepting = (r.state != can_mode_filter_pkg::CTL_OFF) &
      r.module_on & ~r.halted &
      (r.mode_status != `MODE_CONFIG) & (r.mode_status != `MODE_DISABLE);
   // Messages for a disabled filter or an inactive module are consumed
   // and dropped, but only while the buffer has room; the sender stalls while it is full.
   assign buf_in_valid = rx_valid & buf_in_ready & accepting &
      hit_filter.filter_enable;
   always_comb begin
      buf_in_rec.fifo_select = hit_filter.filter_fifo_select;
      buf_in_rec.mask_select = hit_filter.filter_mask_select;
      buf_in_rec.stamp = r.rx_timestamp_capture_enable ?
         16'(r.rx_timestamp_timer) : 16'h0000;
      buf_in_rec.data = rx_data;
   end

   // =======================================================================
   // Next state
   always_comb begin
      logic [31:0] rd;
      logic [7:0] wbyte;
      logic wsel;
      rd = 32'h0000_0000;
      wbyte = 8'h00;
      wsel = 1'b0;
      next_r = r;

      // Register read image.
      if (hit_ctl) begin
         rd[`CTL_ABORT_BIT] = r.abort_all_tx_request;
         rd[`CTL_REQ_LSB+:3] = r.mode_request;
         rd[`CTL_STAT_LSB+:3] = r.mode_status;
         rd[`CTL_CAP_BIT] = r.rx_timestamp_capture_enable;
         rd[`CTL_ON_BIT] = r.module_on;
         rd[`CTL_STOP_IN_IDLE_BIT] = r.stop_in_idle;
         rd[`CTL_BUSY_BIT] = r.module_busy_flag;
      end else if (hit_f1) begin
         rd = r.filter[`FLT_PER_WORD-1:0];
      end else if (hit_f4) begin
         rd = r.filter[NUM_FILTERS-1:`FLT_PER_WORD];
      end
      next_r.pready = access_wait;
      next_r.pslverr = access_wait & ~(hit_ctl | hit_f1 | hit_f4);
      next_r.prdata = (access_wait & ~pwrite) ? rd : 32'h0000_0000;

      // Abort is cleared by hardware once the transmitters are idle; a new
      // request in the same cycle wins over the clear.
      if (r.abort_all_tx_request & tx_all_idle) begin
         next_r.abort_all_tx_request = 1'b0;
      end
      if (abort_set) begin
         next_r.abort_all_tx_request = 1'b1;
      end

      if (wr_ctl) begin
         next_r.mode_request = pwdata[`CTL_REQ_LSB+:3];
         next_r.rx_timestamp_capture_enable = pwdata[`CTL_CAP_BIT];
         next_r.module_on = pwdata[`CTL_ON_BIT];
         next_r.stop_in_idle = pwdata[`CTL_STOP_IN_IDLE_BIT];
      end

      // Filter bytes: enable is always writable, fields only while off.
      for (int i = 0; i < NUM_FILTERS; i++) begin
         wsel = (i < `FLT_PER_WORD) ? wr_f1 : wr_f4;
         wbyte = pwdata[(i % `FLT_PER_WORD) * `FLT_BYTE_WIDTH +:
            `FLT_BYTE_WIDTH];
         if (wsel) begin
            next_r.filter[i].filter_enable = wbyte[`FLT_EN_BIT];
            if (!r.filter[i].filter_enable) begin
               next_r.filter[i].filter_mask_select = wbyte[6:5];
               next_r.filter[i].filter_fifo_select = wbyte[4:0];
            end
         end
      end

      next_r.halted = r.stop_in_idle & system_idle;

      // The timer only runs while capture is on and the module is awake.
      if (r.rx_timestamp_capture_enable & r.module_busy_flag &
          ~r.halted) begin
         next_r.rx_timestamp_timer = r.rx_timestamp_timer +
            TIMER_WIDTH'(1);
      end

      // Mode and enable sequencing; mode changes and switching off wait for a quiet link.
      unique case (r.state)
         can_mode_filter_pkg::CTL_OFF: begin
            if (r.module_on) begin
               next_r.state = can_mode_filter_pkg::CTL_RUN;
            end
         end
         can_mode_filter_pkg::CTL_RUN: begin
            if (!r.module_on && link_idle) begin
               next_r.state = can_mode_filter_pkg::CTL_OFF;
            end else if (r.module_on && !req_reserved &&
                         r.mode_request != r.mode_status) begin
               next_r.state = can_mode_filter_pkg::CTL_CHANGE;
            end
         end
         can_mode_filter_pkg::CTL_CHANGE: begin
            if (link_idle) begin
               if (!req_reserved) begin
                  next_r.mode_status = r.mode_request;
               end
               next_r.state = can_mode_filter_pkg::CTL_RUN;
            end
         end
      endcase
      next_r.module_busy_flag =
         next_r.state != can_mode_filter_pkg::CTL_OFF;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= RESET_STATE;
      end else begin
         r <= next_r;
      end
   end

   // =======================================================================
   // Message buffer
   stream_buffer #(
      .WIDTH($bits(can_mode_filter_pkg::rx_rec_s)),
      .DEPTH(BUF_DEPTH)
   ) stream_buffer_inst (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(buf_in_valid),
      .in_data(buf_in_rec),
      .in_ready(buf_in_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_rec),
      .out_ready(fifo_ready)
   );

   // =======================================================================
   // Outputs
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;
   assign tx_abort_all = r.abort_all_tx_request;
   assign module_active = r.module_busy_flag;
   assign mode_status = r.mode_status;
   assign rx_ready = buf_in_ready;

   // =======================================================================
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_abort_clear;
      r.abort_all_tx_request && tx_all_idle && !abort_set
         |=> !tx_abort_all;
   endproperty
   a_abort_clear: assert property (p_abort_clear)
      else $error("abort request not cleared after transmitters idle");

   property p_abort_only_by_write;
      $rose(tx_abort_all) |-> $past(abort_set);
   endproperty
   a_abort_only_by_write: assert property (p_abort_only_by_write)
      else $error("abort request rose without a software write");

   property p_abort_set;
      abort_set |=> tx_abort_all;
   endproperty
   a_abort_set: assert property (p_abort_set)
      else $error("abort request not raised by a software write");

   property p_abort_held;
      tx_abort_all && !tx_all_idle |=> tx_abort_all;
   endproperty
   a_abort_held: assert property (p_abort_held)
      else $error("abort request dropped while transmitters busy");

   property p_status_legal;
      mode_status != `MODE_RESERVED_A && mode_status != `MODE_RESERVED_B;
   endproperty
   a_status_legal: assert property (p_status_legal)
      else $error("mode status shows a reserved code");

   property p_status_on_completion;
      !$stable(mode_status) |->
         $past(r.state == can_mode_filter_pkg::CTL_CHANGE && link_idle)
         && mode_status == $past(r.mode_request);
   endproperty
   a_status_on_completion: assert property (p_status_on_completion)
      else $error("mode status changed outside a completed transition");

   property p_reserved_ignored;
      r.state == can_mode_filter_pkg::CTL_RUN && req_reserved
         |=> $stable(mode_status) [*2];
   endproperty
   a_reserved_ignored: assert property (p_reserved_ignored)
      else $error("reserved mode request changed the mode");

   property p_busy_until_idle;
      r.module_busy_flag && !r.module_on && !link_idle
         |=> module_active;
   endproperty
   a_busy_until_idle: assert property (p_busy_until_idle)
      else $error("module stopped during a frame");

   property p_off_when_idle;
      r.state == can_mode_filter_pkg::CTL_RUN && !r.module_on && link_idle
         |=> !module_active;
   endproperty
   a_off_when_idle: assert property (p_off_when_idle)
      else $error("module still active after the link went quiet");

   property p_filter_locked;
      r.filter[0].filter_enable && wr_f1
         |=> $stable(r.filter[0].filter_mask_select) &&
             $stable(r.filter[0].filter_fifo_select);
   endproperty
   a_filter_locked: assert property (p_filter_locked)
      else $error("fields of an enabled filter changed");

   property p_timer_stopped;
      !r.rx_timestamp_capture_enable |=> $stable(r.rx_timestamp_timer);
   endproperty
   a_timer_stopped: assert property (p_timer_stopped)
      else $error("timestamp timer ran with capture disabled");

   property p_halt_blocks_rx;
      r.stop_in_idle && system_idle |=> !buf_in_valid;
   endproperty
   a_halt_blocks_rx: assert property (p_halt_blocks_rx)
      else $error("message accepted while halted in idle");

   property p_route;
      buf_in_valid && !fifo_valid |=> fifo_valid &&
         $past(hit_filter.filter_enable) &&
         fifo_rec.fifo_select == $past(hit_filter.filter_fifo_select);
   endproperty
   a_route: assert property (p_route)
      else $error("message routed through a wrong or disabled filter");

endmodule
`default_nettype wire

// >>> core/can_mode_filter_defines.svh
// Contract
// - A software write of one to the abort request drives the abort to every transmit buffer, and the block clears the bit once all of them report idle.
// - The three-bit mode request selects normal 000, disable 001, loopback 010, listen only 011, configuration 100 or listen all 111; 101 and 110 are reserved.
// - The read-only mode status shows the mode actually in force, coded like the mode request.
// - After reset both the mode request and the mode status hold 100, configuration mode.
// - With capture enabled the timer value is stored with each accepted message; with it off the timer stops and no value is captured.
// - The module on bit enables the module; after it is cleared the block may finish the current frame before it stops.
// - With stop in idle set the block halts while the system is idle, and otherwise it keeps running.
// - Each acceptance filter has its own enable bit, one to activate it and zero to deactivate it.
// - Each filter's two-bit mask select picks acceptance mask 0 to 3.
// - Each filter's five-bit FIFO select names receive FIFO 0 to 31 for a matching message.
// - A filter byte holds enable at bit 7, mask select at bits 6 to 5 and FIFO select at bits 4 to 0, four filters to a word, lowest filter in the low byte.
// - A filter's control fields change only while that filter's enable is zero.
// - The abort request is set by software only, cleared by hardware only, and reads zero after reset.
`ifndef CAN_MODE_FILTER_DEFINES_SVH
`define CAN_MODE_FILTER_DEFINES_SVH

// ==========================================================================
// Register offsets
`define ADDR_MODULE_CONTROL 12'h000
`define ADDR_FILTER_CONTROL_ONE 12'h004
`define ADDR_FILTER_CONTROL_FOUR 12'h008

// ==========================================================================
// Module control fields
`define CTL_ABORT_BIT 27
`define CTL_REQ_LSB 24
`define CTL_STAT_LSB 21
`define CTL_CAP_BIT 20
`define CTL_ON_BIT 15
`define CTL_STOP_IN_IDLE_BIT 13
`define CTL_BUSY_BIT 11

// ==========================================================================
// Mode codes
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_CONFIG 3'h4
`define MODE_RESERVED_A 3'h5
`define MODE_RESERVED_B 3'h6
`define MODE_LISTEN_ALL 3'h7

// ==========================================================================
// Filter byte layout and reset values
`define FLT_EN_BIT 7
`define FLT_BYTE_WIDTH 8
`define FLT_PER_WORD 4
`define FLT_RESET 8'h00
`define TIMER_RESET 16'h0000

`endif

// >>> core/can_mode_filter_pkg.sv
`default_nettype none
package can_mode_filter_pkg;

   // ========================================================================
   // Control state
   typedef enum logic [2:0] {
      CTL_OFF = 3'b001,
      CTL_RUN = 3'b010,
      CTL_CHANGE = 3'b100
   } ctl_state_e;

   // ========================================================================
   // One filter control byte, enable in the top bit
   typedef struct packed {
      logic filter_enable;
      logic [1:0] filter_mask_select;
      logic [4:0] filter_fifo_select;
   } filter_byte_s;

   // ========================================================================
   // Accepted message handed to the receive FIFO store
   typedef struct packed {
      logic [4:0] fifo_select;
      logic [1:0] mask_select;
      logic [15:0] stamp;
      logic [31:0] data;
   } rx_rec_s;

endpackage
`default_nettype wire

// >>> core/stream_buffer.sv
`default_nettype none
module stream_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [CW-1:0] count;
      logic in_ready;
      logic out_valid;
   } state_s;

   localparam state_s RESET_STATE = '{slot: '0, count: '0,
      in_ready: 1'b1, out_valid: 1'b0};

   state_s r;
   state_s next_r;

   // Slot 0 is the head; a pop shifts the rest down one place.
   always_comb begin
      logic push;
      logic pop;
      logic [CW-1:0] idx;
      push = in_valid & r.in_ready;
      pop = r.out_valid & out_ready;
      next_r = r;
      idx = r.count;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_r.slot[i] = r.slot[i+1];
         end
         idx = r.count - CW'(1);
      end
      if (push) begin
         next_r.slot[idx] = in_data;
      end
      next_r.count = r.count + CW'(push) - CW'(pop);
      next_r.in_ready = next_r.count != FULL;
      next_r.out_valid = next_r.count != '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= RESET_STATE;
      end else begin
         r <= next_r;
      end
   end

   assign in_ready = r.in_ready;
   assign out_valid = r.out_valid;
   assign out_data = r.slot[0];

endmodule
`default_nettype wire

// >>> tb/can_net_model.sv
`default_nettype none
module can_net_model #(
   parameter int ABORT_CYCLES = 30
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rx_ready,
   input wire logic tx_abort_all,
   output logic rx_valid,
   output logic [2:0] rx_filter,
   output logic [31:0] rx_data,
   output logic link_idle,
   output logic tx_all_idle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tx_pending = 1'b0;
   logic tx_load = 1'b0;
   int abort_cnt;
   initial begin
      rx_valid = 1'b0;
      rx_filter = 3'h0;
      rx_data = 32'hffff_ffff;
      link_idle = 1'b1;
   end
   assign tx_all_idle = !tx_pending;
   // ======================================================================
   // A pending frame takes a while to abandon, as on a busy network.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_cnt <= 0;
         tx_pending <= 1'b0;
      end else if (tx_load) begin
         tx_pending <= 1'b1;
      end else if (tx_abort_all && tx_pending) begin
         abort_cnt <= abort_cnt + 1;
         if (abort_cnt == ABORT_CYCLES) begin
            tx_pending <= 1'b0;
         end
      end else begin
         abort_cnt <= 0;
      end
   end
   task automatic load_tx();
      @(posedge pclk);
      tx_load <= 1'b1;
      @(posedge pclk);
      tx_load <= 1'b0;
   endtask
   task automatic set_link(input logic idle);
      @(posedge pclk);
      link_idle <= idle;
   endtask
   // ======================================================================
   // Released data shows the inverse of the last word, never a stale copy.
   task automatic send(input logic [2:0] f, input logic [31:0] d);
      int n;
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_filter <= f;
      rx_data <= d;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rx_ready !== 1'b1 && n < 100);
      rx_valid <= 1'b0;
      rx_data <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`include "can_mode_filter_defines.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic system_idle = 1'b0;
   logic fifo_ready = 1'b0;
   logic pready, pslverr, tx_abort_all, module_active, fifo_valid;
   logic rx_valid, rx_ready, link_idle, tx_all_idle;
   logic [2:0] rx_filter, mode_status, prev, req, exp;
   logic [31:0] prdata, rx_data, r, w1;
   logic [15:0] stamp, s1;
   logic e;
   can_mode_filter_pkg::rx_rec_s fifo_rec;
   int n_errors = 0;
   int cmp_count = 0;
   int n;
   logic [2:0] codes [9] = '{`MODE_NORMAL, `MODE_DISABLE, `MODE_LOOPBACK,
      `MODE_LISTEN_ONLY, `MODE_LISTEN_ALL, `MODE_CONFIG, `MODE_RESERVED_A,
      `MODE_RESERVED_B, `MODE_NORMAL};
   always #5 pclk = ~pclk;
   can_mode_filter_ctrl can_mode_filter_ctrl_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .link_idle(link_idle), .tx_all_idle(tx_all_idle),
      .system_idle(system_idle), .tx_abort_all(tx_abort_all),
      .module_active(module_active), .mode_status(mode_status),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_filter(rx_filter),
      .rx_data(rx_data), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
      .fifo_rec(fifo_rec));
   can_net_model can_net_model_inst (.pclk(pclk), .presetn(presetn),
      .rx_ready(rx_ready), .tx_abort_all(tx_abort_all),
      .rx_valid(rx_valid), .rx_filter(rx_filter), .rx_data(rx_data),
      .link_idle(link_idle), .tx_all_idle(tx_all_idle));
   // ======================================================================
   // Bus tasks
   task automatic chk(input string what, input logic [31:0] x,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, x, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) n_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk("write error", 32'h0, 32'(e));
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                      input string what);
      apb(1'b0, a, 32'h0);
      chk(what, x, r);
   endtask
   function automatic logic [31:0] cw(input logic ab, input logic [2:0] rq,
      input logic [2:0] st, input logic cap, input logic on,
      input logic sid, input logic busy);
      return {4'h0, ab, rq, st, cap, 4'h0, on, 1'b0, sid, 1'b0, busy, 11'h0};
   endfunction
   task automatic take(input logic [4:0] fs, input logic [1:0] ms,
                       input logic [31:0] d);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (fifo_valid !== 1'b1 && k < 40);
      chk("fifo valid", 32'h1, 32'(fifo_valid));
      chk("fifo select", 32'(fs), 32'(fifo_rec.fifo_select));
      chk("mask select", 32'(ms), 32'(fifo_rec.mask_select));
      chk("record data", d, fifo_rec.data);
      stamp = fifo_rec.stamp;
      fifo_ready <= 1'b1;
      @(posedge pclk);
      fifo_ready <= 1'b0;
   endtask
   task automatic drop(input logic [2:0] f);
      can_net_model_inst.send(f, 32'h0bad_0000);
      repeat (5) @(posedge pclk);
      chk("dropped", 32'h0, 32'(fifo_valid));
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      close_out();
   end
   // ======================================================================
   // Tests
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`ADDR_MODULE_CONTROL, cw(0, 4, 4, 0, 0, 0, 0), "ctl");
      rdc(`ADDR_FILTER_CONTROL_ONE, 32'h0, "filter one reset");
      rdc(`ADDR_FILTER_CONTROL_FOUR, 32'h0, "filter four reset");
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped data", 32'h0, r);
      chk("unmapped error", 32'h1, 32'(e));
      $display("test reset done");
      wr(`ADDR_MODULE_CONTROL, cw(0, `MODE_CONFIG, 0, 0, 1, 0, 0));
      repeat (3) @(posedge pclk);
      chk("module active", 32'h1, 32'(module_active));
      prev = `MODE_CONFIG;
      for (int i = 0; i < 9; i++) begin
         req = codes[i];
         exp = (req == `MODE_RESERVED_A || req == `MODE_RESERVED_B) ?
               prev : req;
         can_net_model_inst.set_link(1'b0);
         wr(`ADDR_MODULE_CONTROL, cw(0, req, 0, 0, 1, 0, 0));
         repeat (4) @(posedge pclk);
         chk("status in frame", 32'(prev), 32'(mode_status));
         can_net_model_inst.set_link(1'b1);
         n = 0;
         while (mode_status !== exp && n < 40) begin
            @(posedge pclk);
            n++;
         end
         repeat (2) @(posedge pclk);
         chk("mode status", 32'(exp), 32'(mode_status));
         rdc(`ADDR_MODULE_CONTROL, cw(0,req,exp,0,1,0,1), "ctl");
         prev = exp;
      end
      $display("test modes done");
      w1 = 32'hfec5_bf80;
      wr(`ADDR_FILTER_CONTROL_ONE, w1);
      wr(`ADDR_FILTER_CONTROL_FOUR, 32'h00a3_003f);
      wr(`ADDR_FILTER_CONTROL_ONE, 32'h9f9f_9f9f);
      rdc(`ADDR_FILTER_CONTROL_ONE, w1, "filter one held");
      rdc(`ADDR_FILTER_CONTROL_FOUR, 32'h00a3_003f, "filter four");
      for (int i = 0; i < 4; i++) begin
         can_net_model_inst.send(3'(i), 32'h1234_5600 + i);
         take(w1[8*i +: 5], w1[8*i+5 +: 2], 32'h1234_5600 + i);
         chk("stamp off", 32'h0, 32'(stamp));
      end
      can_net_model_inst.send(3'h6, 32'h5a5a_0006);
      take(5'h03, 2'h1, 32'h5a5a_0006);
      drop(3'h4);
      can_net_model_inst.send(3'h0, 32'ha000_0001);
      can_net_model_inst.send(3'h1, 32'ha000_0002);
      @(posedge pclk);
      chk("buffer full", 32'h0, 32'(rx_ready));
      take(5'h00, 2'h0, 32'ha000_0001);
      take(5'h1f, 2'h1, 32'ha000_0002);
      wr(`ADDR_FILTER_CONTROL_ONE, 32'h0);
      wr(`ADDR_FILTER_CONTROL_ONE, 32'h0000_0041);
      rdc(`ADDR_FILTER_CONTROL_ONE, 32'h0000_0041, "filter new");
      wr(`ADDR_FILTER_CONTROL_ONE, w1);
      $display("test filters done");
      wr(`ADDR_MODULE_CONTROL, cw(0, 0, 0, 1, 1, 0, 0));
      can_net_model_inst.send(3'h0, 32'h0000_0c01);
      take(5'h00, 2'h0, 32'h0000_0c01);
      s1 = stamp;
      repeat (6) @(posedge pclk);
      can_net_model_inst.send(3'h0, 32'h0000_0c02);
      take(5'h00, 2'h0, 32'h0000_0c02);
      chk("stamp runs", 32'h1, 32'(stamp != s1));
      $display("test capture done");
      wr(`ADDR_MODULE_CONTROL, cw(0, 0, 0, 0, 1, 1, 0));
      @(posedge pclk);
      system_idle <= 1'b1;
      drop(3'h0);
      @(posedge pclk);
      system_idle <= 1'b0;
      can_net_model_inst.send(3'h1, 32'h0000_1d01);
      take(5'h1f, 2'h1, 32'h0000_1d01);
      wr(`ADDR_MODULE_CONTROL, cw(0, 0, 0, 0, 1, 0, 0));
      @(posedge pclk);
      system_idle <= 1'b1;
      can_net_model_inst.send(3'h2, 32'h0000_1d02);
      take(5'h05, 2'h2, 32'h0000_1d02);
      system_idle <= 1'b0;
      $display("test idle done");
      can_net_model_inst.load_tx();
      wr(`ADDR_MODULE_CONTROL, cw(1, 0, 0, 0, 1, 0, 0));
      @(posedge pclk);
      chk("abort out", 32'h1, 32'(tx_abort_all));
      wr(`ADDR_MODULE_CONTROL, cw(0, 0, 0, 0, 1, 0, 0));
      rdc(`ADDR_MODULE_CONTROL, cw(1,0,0,0,1,0,1), "abort held");
      n = 0;
      while (tx_abort_all !== 1'b0 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      chk("abort done", 32'h1, 32'(tx_all_idle));
      rdc(`ADDR_MODULE_CONTROL, cw(0,0,0,0,1,0,1), "abort clr");
      $display("test abort done");
      can_net_model_inst.set_link(1'b0);
      wr(`ADDR_MODULE_CONTROL, cw(0, 0, 0, 0, 0, 0, 0));
      repeat (4) @(posedge pclk);
      chk("still active", 32'h1, 32'(module_active));
      can_net_model_inst.set_link(1'b1);
      n = 0;
      do begin
         apb(1'b0, `ADDR_MODULE_CONTROL, 32'h0);
         n++;
      end while (r[`CTL_BUSY_BIT] !== 1'b0 && n < 20);
      chk("busy flag", 32'h0, 32'(r[`CTL_BUSY_BIT]));
      chk("module off", 32'h0, 32'(module_active));
      drop(3'h0);
      $display("test off done");
      close_out();
   end
endmodule
`default_nettype wire
